// >>> sfcd_pkg.sv
// package for the serial flash command decoder: opcodes, states, carriers
// assumes a single 100 MHz core clock samples the serial link
`default_nettype none
package sfcd_pkg;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE_64 = 8'hd8;
	localparam logic [7:0] OP_STATUS_READ    = 8'h05;
	localparam logic [7:0] OP_CONFIG_READ    = 8'h15;
	localparam logic [7:0] OP_SUSPEND_A      = 8'h75;
	localparam logic [7:0] OP_SUSPEND_B      = 8'hb0;
	localparam logic [7:0] OP_WRITE_SET      = 8'h06;
	localparam logic [7:0] OP_WRITE_CLR      = 8'h04;
	localparam logic [7:0] OP_RESUME_A       = 8'h7a;
	localparam logic [7:0] OP_RESUME_B       = 8'h30;

	// ---------------------------------------------------------------
	// counts
	// ---------------------------------------------------------------
	localparam int          ADDR_BYTES = 3;
	localparam logic [2:0]  BIT_LAST   = 3'h7;
	localparam logic [1:0]  ADDR_LAST  = 2'h2;
	localparam logic [23:0] ADDR_ZERO  = 24'h000000;

	typedef enum logic [2:0] {
		ST_OPCODE  = 3'b000,
		ST_ADDRESS = 3'b001,
		ST_DATA    = 3'b010,
		ST_OUTPUT  = 3'b011,
		ST_CONTROL = 3'b100,
		ST_STANDBY = 3'b101
	} sfcd_state_type;

	typedef enum logic [2:0] {
		OPK_NONE    = 3'b000,
		OPK_PROGRAM = 3'b001,
		OPK_SECTOR  = 3'b010,
		OPK_BLOCK   = 3'b011,
		OPK_SUSPEND = 3'b100,
		OPK_RESUME  = 3'b101,
		OPK_WSET    = 3'b110,
		OPK_WCLR    = 3'b111
	} sfcd_opk_type;

	// dispatched operation toward the program/erase engine
	typedef struct packed {
		logic         valid;
		sfcd_opk_type kind;
		logic [23:0]  addr;
	} sfcd_cmd_type;

	// one data byte of a page program
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} sfcd_byte_type;
endpackage
`default_nettype wire

// >>> sfcd_edge.sv
// link sampler: two-flop synchroniser plus edge finder for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module sfcd_edge #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// reset to the pin's idle level so no false edge follows reset;
	// the pin reaches the first flop raw, with no gate in front of it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
			last_ff <= RST_VAL;
		end else begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise  = sync_ff & ~last_ff;
	assign fall  = ~sync_ff & last_ff;
endmodule
`default_nettype wire

// >>> sfcd_top.sv
// serial flash command decoder: collects opcode and address, dispatches operations
// assumes the host drives cs_n and sclk slower than ref_clk/4; engine gives busy
`timescale 1ns/1ps
`default_nettype none
module sfcd_top (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             cs_n,
	input  wire logic             sclk,
	input  wire logic             si,
	input  wire logic [7:0]       status_val,
	input  wire logic [7:0]       config1_val,
	input  wire logic [7:0]       config2_val,
	input  wire logic             engine_busy,
	output logic                  so,
	output logic                  so_oe,
	output logic                  write_enable_latch,
	output sfcd_pkg::sfcd_cmd_type  cmd,
	output sfcd_pkg::sfcd_byte_type prog_byte
);
	import sfcd_pkg::*;

	// ---------------------------------------------------------------
	// link sampling
	// ---------------------------------------------------------------
	logic cs_lvl, cs_rise, cs_fall;
	logic sck_lvl, sck_rise, sck_fall;
	logic si_lvl;

	sfcd_edge #(.RST_VAL(1'b1)) u_cs (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     (cs_n),
		.level   (cs_lvl),
		.rise    (cs_rise),
		.fall    (cs_fall)
	);
	sfcd_edge #(.RST_VAL(1'b0)) u_sck (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     (sclk),
		.level   (sck_lvl),
		.rise    (sck_rise),
		.fall    (sck_fall)
	);
	sfcd_edge #(.RST_VAL(1'b0)) u_si (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     (si),
		.level   (si_lvl),
		.rise    (),
		.fall    ()
	);

	// data pin shares the clock pin's delay so rising-edge samples line up
	wire active   = ~cs_lvl;
	// mode 3 idles high: the edge that drops sclk right after cs falls is not a shift edge
	wire bit_in   = active & sck_rise;
	wire bit_out  = active & sck_fall;

	function automatic sfcd_opk_type decode_op(input logic [7:0] op);
		case (op)
			OP_PAGE_PROGRAM:              decode_op = OPK_PROGRAM;
			OP_SECTOR_ERASE:              decode_op = OPK_SECTOR;
			OP_BLOCK_ERASE_64:            decode_op = OPK_BLOCK;
			OP_SUSPEND_A, OP_SUSPEND_B:   decode_op = OPK_SUSPEND;
			OP_RESUME_A, OP_RESUME_B:     decode_op = OPK_RESUME;
			OP_WRITE_SET:                 decode_op = OPK_WSET;
			OP_WRITE_CLR:                 decode_op = OPK_WCLR;
			default:                      decode_op = OPK_NONE;
		endcase
	endfunction

	function automatic logic needs_latch(input sfcd_opk_type k);
		needs_latch = (k == OPK_PROGRAM) || (k == OPK_SECTOR) || (k == OPK_BLOCK);
	endfunction

	// ---------------------------------------------------------------
	// byte assembly
	// ---------------------------------------------------------------
	sfcd_state_type state_ff;
	logic [2:0]     bit_cnt_ff;
	logic [7:0]     shift_ff;
	logic [1:0]     addr_cnt_ff;
	logic [23:0]    addr_ff;
	sfcd_opk_type   kind_ff;
	logic           on_boundary_ff;

	wire [7:0] full_byte  = {shift_ff[6:0], si_lvl};
	wire       byte_done  = bit_in && (bit_cnt_ff == BIT_LAST);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bit_cnt_ff <= 3'h0;
			shift_ff   <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt_ff <= 3'h0;
			shift_ff   <= 8'h00;
		end else if (bit_in) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			shift_ff   <= full_byte;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			on_boundary_ff <= 1'b1;
		end else if (cs_fall) begin
			on_boundary_ff <= 1'b1;
		end else if (bit_in) begin
			on_boundary_ff <= (bit_cnt_ff == BIT_LAST);
		end
	end

	// ---------------------------------------------------------------
	// command state machine
	// ---------------------------------------------------------------
	sfcd_opk_type nxt_kind;
	assign nxt_kind = decode_op(full_byte);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff    <= ST_OPCODE;
			addr_cnt_ff <= 2'h0;
			addr_ff     <= ADDR_ZERO;
			kind_ff     <= OPK_NONE;
		end else if (cs_fall) begin
			state_ff    <= ST_OPCODE;
			addr_cnt_ff <= 2'h0;
			kind_ff     <= OPK_NONE;
		end else if (byte_done) begin
			case (state_ff)
				ST_OPCODE: begin
					kind_ff <= nxt_kind;
					if (full_byte == OP_STATUS_READ || full_byte == OP_CONFIG_READ) begin
						state_ff <= ST_OUTPUT;
					end else if (nxt_kind == OPK_PROGRAM || nxt_kind == OPK_SECTOR ||
					             nxt_kind == OPK_BLOCK) begin
						state_ff <= ST_ADDRESS;
					end else if (nxt_kind != OPK_NONE) begin
						state_ff <= ST_CONTROL;
					end else begin
						state_ff <= ST_STANDBY;
					end
				end
				ST_ADDRESS: begin
					addr_ff <= {addr_ff[15:0], full_byte};
					addr_cnt_ff <= addr_cnt_ff + 2'h1;
					if (addr_cnt_ff == ADDR_LAST) begin
						state_ff <= (kind_ff == OPK_PROGRAM) ? ST_DATA : ST_CONTROL;
					end
				end
				ST_CONTROL: begin
					// extra bytes after a control command spoil it
					state_ff <= ST_STANDBY;
				end
				ST_DATA, ST_OUTPUT, ST_STANDBY: begin
					state_ff <= state_ff;
				end
				default: begin
					state_ff <= ST_STANDBY;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// dispatch at deselect; program data bytes pass on as each completes
	// ---------------------------------------------------------------
	wire ends_ok = cs_rise && on_boundary_ff &&
	               (state_ff == ST_CONTROL || state_ff == ST_DATA);
	wire latch_ok = !needs_latch(kind_ff) || write_enable_latch;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmd <= '0;
		end else begin
			cmd.valid <= 1'b0;
			if (ends_ok && latch_ok && (kind_ff != OPK_WSET) && (kind_ff != OPK_WCLR) &&
			    !(kind_ff == OPK_SUSPEND && !engine_busy)) begin
				cmd.valid <= 1'b1;
				cmd.kind  <= kind_ff;
				cmd.addr  <= addr_ff;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prog_byte <= '0;
		end else begin
			prog_byte.valid <= byte_done && (state_ff == ST_DATA) && write_enable_latch;
			if (byte_done) begin
				prog_byte.data <= full_byte;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			write_enable_latch <= 1'b0;
		end else if (ends_ok) begin
			if (kind_ff == OPK_WSET) begin
				write_enable_latch <= 1'b1;
			end else if (kind_ff == OPK_WCLR || (needs_latch(kind_ff) && latch_ok) ||
			             (kind_ff == OPK_SUSPEND && engine_busy)) begin
				// cleared by write-clear, an accepted program or erase, or a suspend while busy
				write_enable_latch <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// read-out shifter
	// ---------------------------------------------------------------
	logic [15:0] out_ff;
	logic        out_go_ff;

	// load on the opcode's last rising edge, shift on falling edges
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			out_ff    <= 16'h0000;
			out_go_ff <= 1'b0;
			so        <= 1'b0;
			so_oe     <= 1'b0;
		end else if (!active || state_ff == ST_STANDBY) begin
			out_go_ff <= 1'b0;
			so_oe     <= 1'b0;
		end else if (byte_done && state_ff == ST_OPCODE &&
		             (full_byte == OP_STATUS_READ || full_byte == OP_CONFIG_READ)) begin
			out_ff    <= (full_byte == OP_STATUS_READ) ? {status_val, status_val}
			                                         : {config1_val, config2_val};
			out_go_ff <= 1'b1;
		end else if (bit_out && out_go_ff) begin
			so     <= out_ff[15];
			so_oe  <= 1'b1;
			// status repeats itself; config pair wraps around
			out_ff <= {out_ff[14:0], out_ff[15]};
		end
	end
endmodule
`default_nettype wire

// >>> sfcd_top_props.sv
// assertions on the decoder outputs
// assumes the sfcd_top ports, one clock
`timescale 1ns/1ps
`default_nettype none
module sfcd_top_props
	import sfcd_pkg::*;
(
	input wire logic                    ref_clk,
	input wire logic                    reset,
	input wire logic                    cs_n,
	input wire logic                    engine_busy,
	input wire logic                    so_oe,
	input wire logic                    write_enable_latch,
	input wire sfcd_pkg::sfcd_cmd_type  cmd,
	input wire sfcd_pkg::sfcd_byte_type prog_byte
);
	// ----------
	// checks
	// ----------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic pe;
	assign pe = cmd.valid && (cmd.kind inside {OPK_PROGRAM, OPK_SECTOR, OPK_BLOCK});
	a_cmd_one_cycle: assert property (cmd.valid |=> !cmd.valid)
		else $error("cmd valid held");
	a_byte_one_cycle: assert property (prog_byte.valid |=> !prog_byte.valid)
		else $error("byte valid held");
	a_cmd_after_cs: assert property (cmd.valid |-> cs_n)
		else $error("cmd inside frame");
	// six cycles covers the pin synchroniser and the output flop
	a_oe_idle_low: assert property (cs_n [*6] |-> !so_oe)
		else $error("so driven while idle");
	a_cmd_needs_latch: assert property (pe |-> $past(write_enable_latch))
		else $error("dispatch without latch");
	a_latch_cleared: assert property (pe |-> ##[0:2] !write_enable_latch)
		else $error("latch kept");
	a_suspend_busy: assert property (cmd.valid && cmd.kind == OPK_SUSPEND |-> engine_busy)
		else $error("idle suspend");
	a_latch_set_idle: assert property ($rose(write_enable_latch) |-> cs_n)
		else $error("latch set inside frame");
endmodule
bind sfcd_top sfcd_top_props props_u (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n),
	.engine_busy(engine_busy), .so_oe(so_oe), .write_enable_latch(write_enable_latch),
	.cmd(cmd), .prog_byte(prog_byte));
`default_nettype wire

// >>> sfcd_host.sv
// host model of the serial link: cs_n, sclk, si
// assumes the bench calls its tasks; link period is 8 ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module sfcd_host (
	input  wire logic ref_clk,
	input  wire logic cpol,
	input  wire logic so,
	output var logic  cs_n,
	output var logic  sclk,
	output var logic  si
);
	// ----------
	// frames
	// ----------
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic open_frame();
		@(posedge ref_clk);
		sclk <= cpol;
		half();
		cs_n <= 1'b0;
		half();
	endtask
	// msb first; so read mid high phase
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sclk <= 1'b0;
			si <= tx[i];
			half();
			sclk <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rx[i] = so;
			repeat (2) @(posedge ref_clk);
		end
	endtask
	// cs rises wherever the caller stopped
	task automatic close_frame();
		sclk <= cpol;
		half();
		cs_n <= 1'b1;
		si <= ~si;
		repeat (16) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// >>> tb.sv
// bench for the serial flash command decoder
// assumes sfcd_host as link master, checker bound to sfcd_top
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfcd_pkg::*;
	logic          ref_clk, reset, cpol, engine_busy, cs_n, sclk, si, so, so_oe;
	logic          write_enable_latch;
	logic [7:0]    status_val, config1_val, config2_val, rx;
	sfcd_cmd_type  cmd, last_cmd;
	sfcd_byte_type prog_byte;
	logic [7:0]    pq[$];
	int            miscompares, check_count, ncmd;
	// ----------
	// harness
	// ----------
	sfcd_top dut_u (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si),
		.status_val(status_val), .config1_val(config1_val), .config2_val(config2_val),
		.engine_busy(engine_busy), .so(so), .so_oe(so_oe),
		.write_enable_latch(write_enable_latch), .cmd(cmd), .prog_byte(prog_byte));
	sfcd_host host_u (.ref_clk(ref_clk), .cpol(cpol), .so(so), .cs_n(cs_n), .sclk(sclk),
		.si(si));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (cmd.valid === 1'b1) begin
			ncmd++;
			last_cmd = cmd;
		end
		if (prog_byte.valid === 1'b1)
			pq.push_back(prog_byte.data);
	end
	task automatic check(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic frame(input logic [7:0] b[$], input int nl);
		host_u.open_frame();
		foreach (b[i])
			host_u.xfer(b[i], (i == b.size() - 1) ? nl : 8, rx);
		host_u.close_frame();
	endtask
	task automatic rd2(input logic [7:0] op, output logic [7:0] a, output logic [7:0] c);
		host_u.open_frame();
		host_u.xfer(op, 8, rx);
		host_u.xfer(8'h00, 8, a);
		host_u.xfer(8'h00, 8, c);
		check(so_oe === 1'b1, "so not driven");
		host_u.close_frame();
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_program();
		int n;
		n = ncmd;
		frame({OP_PAGE_PROGRAM, 8'h12, 8'h34, 8'h56, 8'haa}, 8);
		check(ncmd == n && pq.size() == 0, "program without latch");
		frame({OP_WRITE_SET}, 8);
		check(write_enable_latch === 1'b1, "latch not set");
		frame({OP_PAGE_PROGRAM, 8'ha5, 8'h3c, 8'h81, 8'hc3, 8'h5e}, 8);
		check(ncmd == n + 1 && last_cmd.kind === OPK_PROGRAM, "no program");
		check(last_cmd.addr === 24'ha53c81, "program address");
		check(pq.size() == 2 && pq[0] === 8'hc3 && pq[1] === 8'h5e, "program data");
		check(write_enable_latch === 1'b0, "latch kept");
	endtask
	task automatic t_erase();
		logic [7:0]   ops[2] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE_64};
		sfcd_opk_type ks[2] = '{OPK_SECTOR, OPK_BLOCK};
		int           n;
		for (int k = 0; k < 2; k++) begin
			cpol <= k[0];
			frame({OP_WRITE_SET}, 8);
			n = ncmd;
			// full address, then five stray bits: only the boundary test can refuse it
			frame({ops[k], 8'h7e, 8'h80, 8'h01, 8'h00}, 5);
			check(ncmd == n, "erase off boundary");
			frame({ops[k], 8'h7e, 8'h80, 8'h01}, 8);
			check(ncmd == n + 1 && last_cmd.kind === ks[k], "no erase");
			check(last_cmd.addr === 24'h7e8001, "erase address");
		end
	endtask
	task automatic t_reads();
		logic [7:0] a, c;
		status_val <= 8'h96;
		config1_val <= 8'h3c;
		config2_val <= 8'he1;
		for (int k = 0; k < 2; k++) begin
			cpol <= k[0];
			rd2(OP_STATUS_READ, a, c);
			check(a === 8'h96 && c === 8'h96, "status out");
		end
		rd2(OP_CONFIG_READ, a, c);
		check(a === 8'h3c && c === 8'he1, "config out");
		cpol <= 1'b0;
	endtask
	task automatic t_suspend();
		logic [7:0] ops[2] = '{OP_SUSPEND_A, OP_SUSPEND_B};
		logic [7:0] rs[2] = '{OP_RESUME_A, OP_RESUME_B};
		int         n;
		engine_busy <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			n = ncmd;
			frame({ops[k]}, 8);
			check(ncmd == n + 1 && last_cmd.kind === OPK_SUSPEND, "no suspend");
		end
		n = ncmd;
		frame({OP_SUSPEND_A, 8'h00}, 8);
		check(ncmd == n, "control with extra byte");
		engine_busy <= 1'b0;
		n = ncmd;
		frame({OP_SUSPEND_A}, 8);
		check(ncmd == n, "idle suspend");
		for (int k = 0; k < 2; k++) begin
			n = ncmd;
			frame({rs[k]}, 8);
			check(ncmd == n + 1 && last_cmd.kind === OPK_RESUME, "no resume");
		end
	endtask
	task automatic t_unknown();
		host_u.open_frame();
		host_u.xfer(8'h9f, 8, rx);
		host_u.xfer(OP_STATUS_READ, 8, rx);
		host_u.xfer(8'h00, 8, rx);
		check(so_oe === 1'b0, "so driven");
		host_u.close_frame();
		frame({OP_WRITE_SET}, 8);
		check(write_enable_latch === 1'b1, "no restart");
		frame({OP_WRITE_CLR}, 8);
		check(write_enable_latch === 1'b0, "latch not cleared");
	endtask
	task automatic conclude();
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		cpol = 1'b0;
		engine_busy = 1'b0;
		status_val = 8'h00;
		config1_val = 8'h00;
		config2_val = 8'h00;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check(so_oe === 1'b0 && write_enable_latch === 1'b0, "reset values");
		t_program();
		t_erase();
		t_reads();
		t_suspend();
		t_unknown();
		conclude();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
